// ---- core/rps_page_ctl.sv ----
`timescale 1ns/1ps
`default_nettype none
module rps_page_ctl #(
   parameter int NPORT      = rps_pkg::NPORT_DEF,
   parameter int SPREAD_DIV = rps_pkg::SPREAD_DIV
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             acc_valid,
   input  wire logic             acc_write,
   input  wire logic [7:0]       acc_addr,
   input  wire logic [7:0]       acc_wdata,
   input  wire logic             acc_remote,
   input  wire logic             acc_link,
   output logic [7:0]            rd_data,
   output logic                  rd_valid,
   output logic [NPORT-1:0]      pg_wr_en,
   output logic [7:0]            pg_addr,
   output logic [7:0]            pg_wdata,
   output logic [NPORT-1:0]      pg_rd_en,
   input  wire logic [7:0]       pg_rd_data [NPORT],
   input  wire logic [5:0]       port_status [NPORT],
   output logic                  spread_modulation_on,
   output logic                  spread_modulation_rate,
   output logic                  spread_mod_tick
);
   import rps_pkg::*;

   localparam int NCTX = NPORT + 1;
   localparam int CW   = $clog2(SPREAD_DIV);
   localparam logic [CW-1:0] DIV_LAST = CW'(SPREAD_DIV - 1);

   // The field layout holds exactly two ports, and the divider needs a real period.
   generate
      if (NPORT != 2) begin : g_bad_nport
         $error("rps_page_ctl supports exactly two receive ports");
      end
      if (SPREAD_DIV < 2) begin : g_bad_div
         $error("rps_page_ctl needs a modulation period of at least two cycles");
      end
   endgenerate

   logic [1:0] acc_ctx;
   logic       ctx_rd_port [NCTX];
   logic [1:0] ctx_mask    [NCTX];
   logic       ctx_we      [NCTX];

   // Context 0 is local access, context 1 plus n is the back channel over port n.
   assign acc_ctx = acc_remote ? (acc_link ? 2'd2 : 2'd1) : 2'd0;

   // One page select copy per access context.
   generate
      for (genvar c = 0; c < NCTX; c++) begin : g_ctx
         localparam logic [1:0] WRST = (c == 0) ? SEL_WE_RST_LOCAL :
                                       (c == 1) ? SEL_WE_RST_LINK0 : SEL_WE_RST_LINK1;
         rps_sel_if u_if ();
         assign ctx_we[c]      = acc_valid && acc_write && (acc_addr == ADDR_PORT_SEL)
                                 && (acc_ctx == 2'(c));
         assign u_if.we        = ctx_we[c];
         assign u_if.wdata     = acc_wdata;
         assign ctx_rd_port[c] = u_if.rd_port;
         assign ctx_mask[c]    = u_if.wr_mask;
         rps_sel_ctx #(.WE_RST(WRST)) u_ctx (
            .clk  (clk),
            .rstn (rstn),
            .sel  (u_if.ctx)
         );
      end
   endgenerate

   // Address decode and the current context's selections.
   logic       is_sel;
   logic       is_spread;
   logic       is_sts1;
   logic       is_paged;
   logic       cur_rd_port;
   logic [1:0] cur_mask;
   logic [1:0] phys_idx;
   assign is_sel      = acc_addr == ADDR_PORT_SEL;
   assign is_spread   = acc_addr == ADDR_SPREAD;
   assign is_sts1     = acc_addr == ADDR_STS1;
   assign is_paged    = acc_addr >= PAGED_LO;
   assign cur_rd_port = ctx_rd_port[acc_ctx];
   assign cur_mask    = ctx_mask[acc_ctx];
   assign phys_idx    = acc_remote ? {1'b0, acc_link} : 2'b00;

   // Spread control storage; the reserved bits 3:1 keep what software writes.
   logic       spread_on_q;
   logic       spread_rate_q;
   logic [2:0] spread_rsv_q;
   logic       spread_we;
   assign spread_we = acc_valid && acc_write && is_spread;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         spread_on_q   <= SPREAD_ON_RST;
         spread_rate_q <= SPREAD_RATE_RST;
         spread_rsv_q  <= SPREAD_RSV_RST;
      end else if (spread_we) begin
         spread_on_q   <= acc_wdata[SPREAD_ON_BIT];
         spread_rate_q <= acc_wdata[SPREAD_RATE_BIT];
         spread_rsv_q  <= acc_wdata[SPREAD_RSV_HI:SPREAD_RSV_LO];
      end
   end

   assign spread_modulation_on   = spread_on_q;
   assign spread_modulation_rate = spread_rate_q;

   // Read words of each register.
   logic [7:0] sel_word;
   logic [7:0] sts1_word;
   logic [7:0] spread_word;
   logic [7:0] paged_word;
   logic [7:0] rd_mux;
   assign sel_word    = {phys_idx, 1'b0, cur_rd_port, 2'b00, cur_mask};
   assign sts1_word   = {1'b0, cur_rd_port, port_status[cur_rd_port]};
   assign spread_word = {3'b000, spread_on_q, spread_rsv_q, spread_rate_q};
   assign paged_word  = pg_rd_data[cur_rd_port];
   assign rd_mux      = is_sel    ? sel_word    :
                        is_spread ? spread_word :
                        is_sts1   ? sts1_word   :
                        is_paged  ? paged_word  : 8'h00;

   // Paged strobes; the status register is read only, so writes to it go nowhere.
   logic [NPORT-1:0] wr_en_d;
   logic [NPORT-1:0] rd_en_d;
   logic             paged_wr;
   assign paged_wr = acc_valid && acc_write && is_paged && !is_sts1;
   generate
      for (genvar p = 0; p < NPORT; p++) begin : g_port
         assign wr_en_d[p] = paged_wr && cur_mask[p];
         assign rd_en_d[p] = acc_valid && !acc_write && is_paged && (cur_rd_port == 1'(p));
      end
   endgenerate

   // Answers and strobes leave one cycle after the access is taken.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rd_data  <= 8'h00;
         rd_valid <= 1'b0;
         pg_wr_en <= '0;
         pg_rd_en <= '0;
         pg_addr  <= 8'h00;
         pg_wdata <= 8'h00;
      end else begin
         rd_valid <= acc_valid && !acc_write;
         pg_wr_en <= wr_en_d;
         pg_rd_en <= rd_en_d;
         if (acc_valid && !acc_write) begin
            rd_data <= rd_mux;
         end
         if (acc_valid && is_paged) begin
            pg_addr  <= acc_addr;
            pg_wdata <= acc_wdata;
         end
      end
   end

   // Modulation tick divider. It restarts whenever modulation is off, which is safe
   // only because software never changes the rate with modulation running.
   logic [CW-1:0] div_q;
   logic          div_run;
   logic          div_end;
   assign div_run = spread_on_q && spread_rate_q;
   assign div_end = div_q == DIV_LAST;

   always_ff @(posedge clk) begin
      if (!rstn || !div_run) begin
         div_q           <= '0;
         spread_mod_tick <= 1'b0;
      end else begin
         div_q           <= div_end ? '0 : div_q + 1'b1;
         spread_mod_tick <= div_end;
      end
   end

   // Checks on the access path and the modulation tick.
   sequence s_rd_sel_local;
      acc_valid && !acc_write && is_sel && !acc_remote;
   endsequence

   sequence s_rd_sel_remote;
      acc_valid && !acc_write && is_sel && acc_remote;
   endsequence

   sequence s_sel_rd1;
      acc_valid && acc_write && is_sel && acc_wdata[SEL_RD_BIT];
   endsequence

   property p_phys_local;
      @(posedge clk) disable iff (!rstn)
      s_rd_sel_local |=> rd_valid && (rd_data[SEL_PHYS_HI:SEL_PHYS_LO] == 2'b00);
   endproperty
   a_phys_local: assert property (p_phys_local)
      else $error("local page select read shows a nonzero link index");

   property p_phys_remote;
      @(posedge clk) disable iff (!rstn)
      s_rd_sel_remote |=> rd_data[SEL_PHYS_HI:SEL_PHYS_LO] == {1'b0, $past(acc_link)};
   endproperty
   a_phys_remote: assert property (p_phys_remote)
      else $error("remote page select read shows the wrong link index");

   property p_we1_block;
      @(posedge clk) disable iff (!rstn)
      (paged_wr && !cur_mask[1]) |=> !pg_wr_en[1];
   endproperty
   a_we1_block: assert property (p_we1_block)
      else $error("paged write reached port one with its enable clear");

   property p_we0_block;
      @(posedge clk) disable iff (!rstn)
      (paged_wr && !cur_mask[0]) |=> !pg_wr_en[0];
   endproperty
   a_we0_block: assert property (p_we0_block)
      else $error("paged write reached port zero with its enable clear");

   property p_we_both;
      @(posedge clk) disable iff (!rstn)
      (paged_wr && (cur_mask == 2'b11)) |=> (pg_wr_en == 2'b11)
         && (pg_wdata == $past(acc_wdata)) && (pg_addr == $past(acc_addr));
   endproperty
   a_we_both: assert property (p_we_both)
      else $error("write with both enables did not reach both ports together");

   property p_wr_cause;
      @(posedge clk) disable iff (!rstn)
      (pg_wr_en != 2'b00) |-> $past(paged_wr) && ((pg_wr_en & ~$past(cur_mask)) == 2'b00);
   endproperty
   a_wr_cause: assert property (p_wr_cause)
      else $error("paged write strobe without an enabled paged write");

   property p_rst_link1;
      @(posedge clk) disable iff (!rstn)
      $rose(rstn) |-> (ctx_mask[2] == SEL_WE_RST_LINK1) && (ctx_mask[0] == SEL_WE_RST_LOCAL);
   endproperty
   a_rst_link1: assert property (p_rst_link1)
      else $error("port one back channel copy left reset with wrong enables");

   property p_rst_link0;
      @(posedge clk) disable iff (!rstn)
      $rose(rstn) |-> ctx_mask[1] == SEL_WE_RST_LINK0;
   endproperty
   a_rst_link0: assert property (p_rst_link0)
      else $error("port zero back channel copy left reset with wrong enables");

   property p_spread_on;
      @(posedge clk) disable iff (!rstn)
      spread_we |=> spread_modulation_on == $past(acc_wdata[SPREAD_ON_BIT]);
   endproperty
   a_spread_on: assert property (p_spread_on)
      else $error("spread enable output does not follow the written bit");

   property p_tick_gap;
      @(posedge clk) disable iff (!rstn)
      spread_mod_tick |-> $past(div_run) ##1 !spread_mod_tick [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("modulation tick without modulation or too close to the last");

   property p_sts1_port;
      @(posedge clk) disable iff (!rstn)
      (acc_valid && !acc_write && is_sts1) |=> rd_data[STS1_RD_BIT] == $past(cur_rd_port);
   endproperty
   a_sts1_port: assert property (p_sts1_port)
      else $error("status read shows the wrong read port number");

   property p_rd_sel;
      @(posedge clk) disable iff (!rstn)
      (s_sel_rd1 ##1 (acc_valid && !acc_write && is_paged && !is_sts1
                      && (acc_ctx == $past(acc_ctx)) && !is_sel))
      |=> (rd_data == $past(pg_rd_data[1])) && pg_rd_en == 2'b10;
   endproperty
   a_rd_sel: assert property (p_rd_sel)
      else $error("paged read did not come from the selected port");

   property p_spread_rate;
      @(posedge clk) disable iff (!rstn)
      spread_we |=> spread_modulation_rate == $past(acc_wdata[SPREAD_RATE_BIT]);
   endproperty
   a_spread_rate: assert property (p_spread_rate)
      else $error("spread rate output does not follow the written bit");

   // With modulation stopped the tick must fall silent at once, whatever the counter held.
   property p_tick_gate;
      @(posedge clk) disable iff (!rstn)
      !div_run |=> !spread_mod_tick;
   endproperty
   a_tick_gate: assert property (p_tick_gate)
      else $error("modulation tick while modulation is stopped");

   // A read-clear strobe on the wrong port would silently eat the other port's flags.
   property p_rd_strobe;
      @(posedge clk) disable iff (!rstn)
      (acc_valid && !acc_write && is_paged) |=> $onehot(pg_rd_en)
         && (pg_rd_en[1] == $past(cur_rd_port));
   endproperty
   a_rd_strobe: assert property (p_rd_strobe)
      else $error("paged read strobe missing or on the wrong port");

endmodule : rps_page_ctl
`default_nettype wire

// ---- include/rps_pkg.sv ----
package rps_pkg;

   // Register byte addresses on the control access path.
   localparam logic [7:0] ADDR_SPREAD   = 8'h3E;
   localparam logic [7:0] ADDR_PORT_SEL = 8'h4C;
   localparam logic [7:0] ADDR_STS1     = 8'h4D;
   // First address of the per-port paged window.
   localparam logic [7:0] PAGED_LO      = 8'h4D;

   // Field positions in the spread clock control register.
   localparam int SPREAD_ON_BIT   = 4;
   localparam int SPREAD_RATE_BIT = 0;
   localparam int SPREAD_RSV_LO   = 1;
   localparam int SPREAD_RSV_HI   = 3;

   // Field positions in the page select register.
   localparam int SEL_PHYS_LO = 6;
   localparam int SEL_PHYS_HI = 7;
   localparam int SEL_RD_BIT  = 4;
   localparam int SEL_WE1_BIT = 1;
   localparam int SEL_WE0_BIT = 0;

   // Field position of the read port number in the status register.
   localparam int STS1_RD_BIT = 6;

   // Reset values.
   localparam logic       SPREAD_ON_RST     = 1'b0;
   localparam logic       SPREAD_RATE_RST   = 1'b0;
   localparam logic [2:0] SPREAD_RSV_RST    = 3'h0;
   localparam logic       SEL_RD_RST        = 1'b0;
   localparam logic [1:0] SEL_WE_RST_LOCAL  = 2'h0;
   localparam logic [1:0] SEL_WE_RST_LINK0  = 2'h1;
   localparam logic [1:0] SEL_WE_RST_LINK1  = 2'h2;

   // Modulation period in pixel clock cycles.
   localparam int SPREAD_DIV = 3168;

   // Number of receive ports; the access contexts are local plus one per port.
   localparam int NPORT_DEF = 2;

endpackage : rps_pkg

// ---- include/rps_sel_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface rps_sel_if;
   logic       we;
   logic [7:0] wdata;
   logic       rd_port;
   logic [1:0] wr_mask;

   modport bank (output we, output wdata, input rd_port, input wr_mask);
   modport ctx  (input we, input wdata, output rd_port, output wr_mask);
endinterface : rps_sel_if
`default_nettype wire

// ---- core/rps_sel_ctx.sv ----
`timescale 1ns/1ps
`default_nettype none
module rps_sel_ctx #(
   parameter logic [1:0] WE_RST = 2'h0
) (
   input  wire logic clk,
   input  wire logic rstn,
   rps_sel_if.ctx    sel
);
   import rps_pkg::*;

   logic       rd_q;
   logic       rd_d;
   logic [1:0] mask_q;
   logic [1:0] mask_d;

   // Each access context keeps its own copy, so a remote master never sees local settings.
   assign rd_d   = sel.we ? sel.wdata[SEL_RD_BIT] : rd_q;
   assign mask_d = sel.we ? {sel.wdata[SEL_WE1_BIT], sel.wdata[SEL_WE0_BIT]} : mask_q;

   // The write mask reset value depends on which path owns this copy.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rd_q   <= SEL_RD_RST;
         mask_q <= WE_RST;
      end else begin
         rd_q   <= rd_d;
         mask_q <= mask_d;
      end
   end

   assign sel.rd_port = rd_q;
   assign sel.wr_mask = mask_q;
endmodule : rps_sel_ctx
`default_nettype wire

// ---- sim/rps_port_mdl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Stands in for the two receive ports' paged register files behind the bank.
module rps_port_mdl (
   input  wire logic       clk,
   input  wire logic [1:0] pg_wr_en,
   input  wire logic [7:0] pg_addr,
   input  wire logic [7:0] pg_wdata,
   input  wire logic [7:0] acc_addr,
   output logic [7:0]      pg_rd_data [2],
   output logic [5:0]      port_status [2]
);
   logic [7:0] mem_q [2][256];

   // Each port keeps its own bytes, so a write that leaks to the wrong port shows on readback.
   // A plain clocked process, since the initial block below also fills this array.
   always @(posedge clk) begin
      for (int p = 0; p < 2; p++) begin
         if (pg_wr_en[p]) begin
            mem_q[p][pg_addr] <= pg_wdata;
         end
      end
   end

   // Read data follows the address of the access cycle, as the bank samples it then.
   assign pg_rd_data[0] = mem_q[0][acc_addr];
   assign pg_rd_data[1] = mem_q[1][acc_addr];
   // Distinct status patterns let a wrong port choice be seen.
   assign port_status[0] = 6'h15;
   assign port_status[1] = 6'h2A;

   initial begin
      for (int a = 0; a < 256; a++) begin
         mem_q[0][a] = 8'h00;
         mem_q[1][a] = 8'h00;
      end
   end
endmodule : rps_port_mdl
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rps_pkg::*;
   localparam int DIV = 16;
   logic       clk, rstn, acc_valid, acc_write, acc_remote, acc_link;
   logic [7:0] acc_addr, acc_wdata, rd_data, pg_addr, pg_wdata;
   logic       rd_valid, sp_on, sp_rate, sp_tick;
   logic [1:0] pg_wr_en, pg_rd_en;
   logic [7:0] pg_rd_data [2];
   logic [5:0] port_status [2];
   int         mismatches = 0;
   int         checked = 0;
   int         n;

   rps_page_ctl #(.NPORT(2), .SPREAD_DIV(DIV)) DUT (.clk(clk), .rstn(rstn),
      .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
      .acc_wdata(acc_wdata), .acc_remote(acc_remote), .acc_link(acc_link),
      .rd_data(rd_data), .rd_valid(rd_valid), .pg_wr_en(pg_wr_en), .pg_addr(pg_addr),
      .pg_wdata(pg_wdata), .pg_rd_en(pg_rd_en), .pg_rd_data(pg_rd_data),
      .port_status(port_status), .spread_modulation_on(sp_on),
      .spread_modulation_rate(sp_rate), .spread_mod_tick(sp_tick));
   rps_port_mdl mdl (.clk(clk), .pg_wr_en(pg_wr_en), .pg_addr(pg_addr),
      .pg_wdata(pg_wdata), .acc_addr(acc_addr), .pg_rd_data(pg_rd_data),
      .port_status(port_status));

   // Free running clock at 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp8

   // One access per call; it returns one settled step after the edge that answers it.
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic r, input logic l);
      @(posedge clk);
      #1;
      acc_valid = 1'b1;
      acc_write = w;
      acc_addr = a;
      acc_wdata = d;
      acc_remote = r;
      acc_link = l;
      @(posedge clk);
      #1;
      acc_valid = 1'b0;
   endtask : acc

   task automatic chk_rd(input logic [7:0] a, input logic r, input logic l,
                         input logic [7:0] exp);
      acc(1'b0, a, 8'h00, r, l);
      cmp8({7'h00, rd_valid}, 8'h01);
      cmp8(rd_data, exp);
   endtask : chk_rd

   task automatic chk_pw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] en);
      acc(1'b1, a, d, 1'b0, 1'b0);
      cmp8({6'h00, pg_wr_en}, {6'h00, en});
      if (en != 2'h0) begin
         cmp8(pg_addr, a);
         cmp8(pg_wdata, d);
      end
   endtask : chk_pw

   task automatic wait_tick(output int cnt);
      cnt = 0;
      while (sp_tick !== 1'b1 && cnt < 100) begin
         @(posedge clk);
         #1;
         cnt++;
      end
   endtask : wait_tick

   // Each access path sees its own page select with its own write enable default.
   task automatic t_defaults();
      chk_rd(ADDR_PORT_SEL, 1'b0, 1'b0, 8'h00);
      chk_rd(ADDR_PORT_SEL, 1'b1, 1'b0, 8'h01);
      chk_rd(ADDR_PORT_SEL, 1'b1, 1'b1, 8'h42);
      chk_rd(ADDR_SPREAD, 1'b0, 1'b0, 8'h00);
      $display("test defaults done");
   endtask : t_defaults

   // Walks every mask value, including none and both, at scattered paged addresses.
   task automatic t_write_mask();
      acc(1'b1, ADDR_PORT_SEL, 8'h01, 1'b0, 1'b0);
      chk_pw(8'h50, 8'hA5, 2'h1);
      acc(1'b1, ADDR_PORT_SEL, 8'h02, 1'b0, 1'b0);
      chk_pw(8'h50, 8'h5A, 2'h2);
      acc(1'b1, ADDR_PORT_SEL, 8'h00, 1'b0, 1'b0);
      chk_pw(8'h51, 8'h77, 2'h0);
      acc(1'b1, ADDR_PORT_SEL, 8'h03, 1'b0, 1'b0);
      chk_pw(8'h60, 8'hC3, 2'h3);
      chk_pw(8'hFF, 8'h3C, 2'h3);
      chk_pw(ADDR_STS1, 8'h3C, 2'h0);
      $display("test write mask done");
   endtask : t_write_mask

   // Reads follow the read port bit, and the status register names that port.
   task automatic t_read_sel();
      acc(1'b1, ADDR_PORT_SEL, 8'h10, 1'b0, 1'b0);
      chk_rd(ADDR_PORT_SEL, 1'b0, 1'b0, 8'h10);
      chk_rd(8'h50, 1'b0, 1'b0, 8'h5A);
      cmp8({6'h00, pg_rd_en}, 8'h02);
      chk_rd(8'h60, 1'b0, 1'b0, 8'hC3);
      chk_rd(ADDR_STS1, 1'b0, 1'b0, 8'h6A);
      chk_rd(ADDR_PORT_SEL, 1'b1, 1'b1, 8'h42);
      acc(1'b1, ADDR_PORT_SEL, 8'h00, 1'b0, 1'b0);
      chk_rd(8'h50, 1'b0, 1'b0, 8'hA5);
      cmp8({6'h00, pg_rd_en}, 8'h01);
      chk_rd(ADDR_STS1, 1'b0, 1'b0, 8'h15);
      acc(1'b1, 8'h40, 8'hFF, 1'b0, 1'b0);
      chk_rd(8'h40, 1'b0, 1'b0, 8'h00);
      $display("test read select done");
   endtask : t_read_sel

   // A select write must steer the very next access, with no idle cycle between them.
   // Each back channel path then writes through its own default enable.
   task automatic t_back_to_back();
      @(posedge clk);
      #1;
      acc_valid = 1'b1;
      acc_write = 1'b1;
      acc_addr = ADDR_PORT_SEL;
      acc_wdata = 8'h10;
      acc_remote = 1'b0;
      acc_link = 1'b0;
      @(posedge clk);
      #1;
      acc_write = 1'b0;
      acc_addr = 8'h50;
      acc_wdata = 8'h00;
      @(posedge clk);
      #1;
      acc_valid = 1'b0;
      cmp8({7'h00, rd_valid}, 8'h01);
      cmp8(rd_data, 8'h5A);
      cmp8({6'h00, pg_rd_en}, 8'h02);
      acc(1'b1, 8'h70, 8'h99, 1'b1, 1'b1);
      cmp8({6'h00, pg_wr_en}, 8'h02);
      acc(1'b1, 8'h70, 8'h66, 1'b1, 1'b0);
      cmp8({6'h00, pg_wr_en}, 8'h01);
      $display("test back to back done");
   endtask : t_back_to_back

   // Rate goes in first with modulation off, then enable in a second write.
   task automatic t_spread();
      acc(1'b1, ADDR_SPREAD, 8'h01, 1'b0, 1'b0);
      cmp8({6'h00, sp_on, sp_rate}, 8'h01);
      acc(1'b1, ADDR_SPREAD, 8'h11, 1'b0, 1'b0);
      cmp8({6'h00, sp_on, sp_rate}, 8'h03);
      chk_rd(ADDR_SPREAD, 1'b0, 1'b0, 8'h11);
      wait_tick(n);
      @(posedge clk);
      #1;
      wait_tick(n);
      cmp8(8'(n + 1), 8'(DIV));
      acc(1'b1, ADDR_SPREAD, 8'h01, 1'b0, 1'b0);
      cmp8({6'h00, sp_on, sp_rate}, 8'h01);
      wait_tick(n);
      cmp8(8'(n), 8'h64);
      $display("test spread done");
   endtask : t_spread

   task automatic give_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict

   // Main sequence; reset is held for five cycles.
   initial begin
      rstn = 1'b0;
      acc_valid = 1'b0;
      acc_write = 1'b0;
      acc_addr = 8'h00;
      acc_wdata = 8'h00;
      acc_remote = 1'b0;
      acc_link = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_defaults();
      t_write_mask();
      t_read_sel();
      t_back_to_back();
      t_spread();
      give_verdict();
   end

   // The tests need well under a thousand cycles, so this only fires on a hang.
   initial begin
      #20000;
      mismatches++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
